// File: rtl/spl_top.sv
// Purpose: Power state, digital lock detect and acquisition aid control
// Assumes: Phase error samples come once per comparison cycle, core-clocked
// Notes: Power enable pin is asynchronous and is synchronised for logic use
// How it works
// - Power-enable pin low forces full power down, overriding all bits.
// - Pin high and both power-down bits clear gives full power up.
// - A set per-loop power-down bit powers down only that loop.
// - Divider write with auto power-up powers main loop despite its bit.
// - Lock after five consecutive cycles under entry window, 10 or 15 ns.
// - Locked window widens to 20 or 30 ns; exceeding it drops lock.
// - Powered down with lock output selected forces the output low.
// - Quarter-rate setting feeds lock detect every fourth comparison.
// - Combined lock shows low whenever either loop is unlocked.
// - Slip reduction factors one half, quarter, sixteenth are selectable.
// - Slip reduction lowers comparison rate in acquisition, then restores.
// - Both aids raise current during acquisition only; boost adds resistor, and only when slip reduction is off.
// - A timeout counter disengages both aids without further writes.
// - Main current has sixteen steps plus separate acquisition current.
`default_nettype none
module spl_top #(
  parameter int unsigned TIMEOUT_W = 12
) (
  input wire logic clock_i, // Core clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic power_enable_i, // Chip power-enable pin
  input wire logic main_loop_power_down_i, // Main loop power-down bit
  input wire logic aux_loop_power_down_i, // Aux loop power-down bit
  input wire logic auto_power_up_on_divider_write_i, // Auto power-up enable
  input wire logic divider_write_i, // Pulse: main feedback divider written
  input wire logic lock_detect_quarter_rate_i, // Divide lock compare by four
  input wire logic [3:0] test_output_select_i, // Test/lock pin selector
  input wire spl_pkg::spl_phase_type main_phase_i, // Main phase error sample
  input wire spl_pkg::spl_phase_type aux_phase_i, // Aux phase error sample
  input wire logic [1:0] cycle_slip_reduction_i, // Slip reduction factor
  input wire logic boost_enable_i, // Bandwidth boost enable
  input wire logic [TIMEOUT_W-1:0] timeout_cycles_i, // Aid timeout in compares
  input wire logic [3:0] cp_steady_i, // Steady main current step
  input wire logic [3:0] cp_fast_i, // Acquisition main current step
  output logic main_powered_o, // Main loop powered
  output logic aux_powered_o, // Aux loop powered
  output logic main_lock_o, // Main loop locked
  output logic aux_lock_o, // Aux loop locked
  output logic test_lock_output_pin_o, // Test/lock pin level
  output logic [4:0] comp_divide_o, // Comparison divide: 1,2,4,16
  output logic [3:0] cp_current_o, // Main charge-pump step in use
  output logic boost_resistor_o, // Boost resistor switched in
  output logic aid_active_o // Acquisition aid engaged
);
  logic pe_s1_r;
  logic pe_s2_r;
  logic auto_up_r;
  logic [1:0] qdiv_r;
  logic [2:0] mcnt_r;
  logic [2:0] acnt_r;
  logic [TIMEOUT_W-1:0] tmo_r;
  spl_pkg::spl_acq_type acq_r;
  spl_pkg::spl_acq_type acq_nxt;

  // Pin low clears the sync at once; power-up release is synchronised
  always_ff @(posedge clock_i or negedge nrst_i or negedge power_enable_i)
  begin
    if (!nrst_i || !power_enable_i)
    begin
      pe_s1_r <= 1'b0;
      pe_s2_r <= 1'b0;
    end
    else
    begin
      pe_s1_r <= power_enable_i;
      pe_s2_r <= pe_s1_r;
    end
  end

  wire pe_on = pe_s2_r;
  // Auto power-up latch cleared whenever pin is low
  wire auto_up_nxt = pe_on & (auto_up_r |
    (auto_power_up_on_divider_write_i & divider_write_i));
  wire main_pwr_nxt = pe_on & (!main_loop_power_down_i | auto_up_nxt);
  wire aux_pwr_nxt = pe_on & !aux_loop_power_down_i;
  wire any_down = !main_pwr_nxt | !aux_pwr_nxt;

  // Quarter-rate gating of comparison samples
  wire cmp_tick = main_phase_i.valid;
  wire lock_take = lock_detect_quarter_rate_i ? (cmp_tick && qdiv_r == 2'h3)
    : cmp_tick;
  wire aux_take = lock_detect_quarter_rate_i ? (aux_phase_i.valid && qdiv_r == 2'h3)
    : aux_phase_i.valid;

  function automatic logic [2:0] lock_count(input logic [2:0] cnt, input logic take,
    input logic [7:0] err, input logic [7:0] entry);
    logic [2:0] res;
    res = cnt;
    if (take)
    begin
      if (err >= entry)
        res = 3'h0;
      else if (cnt < 3'(spl_pkg::LOCK_CYCLES))
        res = cnt + 3'h1;
    end
    return res;
  endfunction

  function automatic logic lock_next(input logic lk, input logic [2:0] cnt_n,
    input logic take, input logic [7:0] err, input logic [7:0] exitw, input logic pwr);
    logic res;
    res = lk;
    if (!pwr)
      res = 1'b0;
    else if (lk)
    begin
      if (take && err > exitw)
        res = 1'b0;
    end
    else if (cnt_n == 3'(spl_pkg::LOCK_CYCLES))
      res = 1'b1;
    return res;
  endfunction

  wire [2:0] mcnt_c = lock_count(mcnt_r, lock_take, main_phase_i.err_cyc,
    spl_pkg::MAIN_ENTRY_CYC);
  wire [2:0] acnt_c = lock_count(acnt_r, aux_take, aux_phase_i.err_cyc,
    spl_pkg::AUX_ENTRY_CYC);
  wire mlock_nxt = lock_next(main_lock_o, mcnt_c, lock_take, main_phase_i.err_cyc,
    spl_pkg::MAIN_EXIT_CYC, main_pwr_nxt);
  wire alock_nxt = lock_next(aux_lock_o, acnt_c, aux_take, aux_phase_i.err_cyc,
    spl_pkg::AUX_EXIT_CYC, aux_pwr_nxt);
  wire [2:0] mcnt_nxt = (mlock_nxt | !main_pwr_nxt) ? 3'h0 : mcnt_c;
  wire [2:0] acnt_nxt = (alock_nxt | !aux_pwr_nxt) ? 3'h0 : acnt_c;

  wire lock_sel = (test_output_select_i == spl_pkg::SEL_MAIN_LOCK) |
    (test_output_select_i == spl_pkg::SEL_AUX_LOCK) |
    (test_output_select_i == spl_pkg::SEL_BOTH_LOCK);
  wire pin_raw = (test_output_select_i == spl_pkg::SEL_MAIN_LOCK) ? mlock_nxt :
    (test_output_select_i == spl_pkg::SEL_AUX_LOCK) ? alock_nxt :
    (test_output_select_i == spl_pkg::SEL_BOTH_LOCK) ? (mlock_nxt & alock_nxt) :
    1'b0;
  wire pin_nxt = (lock_sel & any_down) ? 1'b0 : pin_raw;

  // Acquisition aids start on divider write, end on timeout
  wire start_acq = divider_write_i & main_pwr_nxt;
  wire tmo_done = (tmo_r == '0);
  always_comb
  begin
    acq_nxt = acq_r;
    case (acq_r)
      spl_pkg::ACQ_IDLE:
      begin
        if (start_acq && cycle_slip_reduction_i != spl_pkg::SLIP_OFF)
          acq_nxt = spl_pkg::ACQ_SLIP;
        else if (start_acq && boost_enable_i)
          acq_nxt = spl_pkg::ACQ_BOOST;
      end
      spl_pkg::ACQ_SLIP:
      begin
        if (tmo_done || !main_pwr_nxt)
          acq_nxt = spl_pkg::ACQ_IDLE;
      end
      spl_pkg::ACQ_BOOST:
      begin
        if (tmo_done || !main_pwr_nxt)
          acq_nxt = spl_pkg::ACQ_IDLE;
      end
      default: acq_nxt = spl_pkg::ACQ_IDLE;
    endcase
  end

  wire [TIMEOUT_W-1:0] tmo_nxt = start_acq ? timeout_cycles_i :
    (cmp_tick && !tmo_done) ? tmo_r - 1'b1 : tmo_r;
  wire [4:0] div_nxt = (acq_nxt != spl_pkg::ACQ_SLIP) ? 5'h01 :
    (cycle_slip_reduction_i == spl_pkg::SLIP_HALF) ? 5'h02 :
    (cycle_slip_reduction_i == spl_pkg::SLIP_QUARTER) ? 5'h04 : 5'h10;
  wire [3:0] cp_nxt = (acq_nxt == spl_pkg::ACQ_IDLE) ? cp_steady_i : cp_fast_i;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      auto_up_r <= 1'b0;
      qdiv_r <= 2'h0;
      mcnt_r <= 3'h0;
      acnt_r <= 3'h0;
      tmo_r <= '0;
      acq_r <= spl_pkg::ACQ_IDLE;
    end
    else
    begin
      auto_up_r <= auto_up_nxt & main_loop_power_down_i;
      qdiv_r <= cmp_tick ? qdiv_r + 2'h1 : qdiv_r;
      mcnt_r <= mcnt_nxt;
      acnt_r <= acnt_nxt;
      tmo_r <= tmo_nxt;
      acq_r <= acq_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      main_powered_o <= 1'b0;
      aux_powered_o <= 1'b0;
      main_lock_o <= 1'b0;
      aux_lock_o <= 1'b0;
      test_lock_output_pin_o <= 1'b0;
      comp_divide_o <= 5'h01;
      cp_current_o <= 4'h0;
      boost_resistor_o <= 1'b0;
      aid_active_o <= 1'b0;
    end
    else
    begin
      main_powered_o <= main_pwr_nxt;
      aux_powered_o <= aux_pwr_nxt;
      main_lock_o <= mlock_nxt;
      aux_lock_o <= alock_nxt;
      test_lock_output_pin_o <= pin_nxt;
      comp_divide_o <= div_nxt;
      cp_current_o <= cp_nxt;
      boost_resistor_o <= (acq_nxt == spl_pkg::ACQ_BOOST);
      aid_active_o <= (acq_nxt != spl_pkg::ACQ_IDLE);
    end
  end
endmodule
`default_nettype wire

// File: rtl/spl_pkg.sv
// Purpose: Shared constants and types for synthesizer power and lock control
// Assumes: Core clock 250 MHz; phase error arrives as a measured width in core cycles
// Notes: Windows in ns are converted to core cycles here
`default_nettype none
package spl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned LOCK_CYCLES = 5;
  localparam int unsigned MAIN_ENTRY_NS = 10;
  localparam int unsigned MAIN_EXIT_NS = 20;
  localparam int unsigned AUX_ENTRY_NS = 15;
  localparam int unsigned AUX_EXIT_NS = 30;
  localparam int unsigned QUARTER_DIV = 4;
  localparam int unsigned ERR_W = 8;
  // Windows as core-cycle counts of phase error width
  localparam logic [7:0] MAIN_ENTRY_CYC = 8'(MAIN_ENTRY_NS / CLK_PERIOD_NS);
  localparam logic [7:0] MAIN_EXIT_CYC = 8'(MAIN_EXIT_NS / CLK_PERIOD_NS);
  localparam logic [7:0] AUX_ENTRY_CYC = 8'(AUX_ENTRY_NS / CLK_PERIOD_NS);
  localparam logic [7:0] AUX_EXIT_CYC = 8'(AUX_EXIT_NS / CLK_PERIOD_NS);
  localparam logic [3:0] SEL_MAIN_LOCK = 4'h2;
  localparam logic [3:0] SEL_AUX_LOCK = 4'h1;
  localparam logic [3:0] SEL_BOTH_LOCK = 4'h3;
  localparam logic [1:0] SLIP_OFF = 2'h0;
  localparam logic [1:0] SLIP_HALF = 2'h1;
  localparam logic [1:0] SLIP_QUARTER = 2'h2;
  localparam logic [1:0] SLIP_SIXTEENTH = 2'h3;
  typedef enum logic [2:0] {
    ACQ_IDLE = 3'b001,
    ACQ_SLIP = 3'b010,
    ACQ_BOOST = 3'b100
  } spl_acq_type;
  typedef struct packed {
    logic valid;
    logic [ERR_W-1:0] err_cyc;
  } spl_phase_type;
endpackage
`default_nettype wire

// File: verif/spl_top_sva.sv
// Purpose: Port checks for spl_top
// Assumes: Bound to every spl_top instance
// Notes: Power pin rise takes three edges to the outputs, fall takes one
`default_nettype none
module spl_top_sva (
  input wire logic clock_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic power_enable_i, // Pin
  input wire logic aux_loop_power_down_i, // Aux off
  input wire logic divider_write_i, // Write
  input wire logic lock_detect_quarter_rate_i, // Quarter
  input wire logic [3:0] test_output_select_i, // Select
  input wire spl_pkg::spl_phase_type main_phase_i, // Sample
  input wire logic [1:0] cycle_slip_reduction_i, // Slip
  input wire logic boost_enable_i, // Boost
  input wire logic main_powered_o, // Main on
  input wire logic aux_powered_o, // Aux on
  input wire logic main_lock_o, // Main lock
  input wire logic test_lock_output_pin_o, // Pin out
  input wire logic [4:0] comp_divide_o, // Divide
  input wire logic boost_resistor_o, // Resistor
  input wire logic aid_active_o // Aid
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_write_aid;
    divider_write_i && main_powered_o && !aid_active_o
      && (cycle_slip_reduction_i != 2'h0 || boost_enable_i);
  endsequence
  a_pin_low_off:
    assert property ((!power_enable_i)[*4] |-> !main_powered_o && !aux_powered_o)
    else $error("power on with pin low");
  a_aux_follows:
    assert property ((power_enable_i && $stable(aux_loop_power_down_i))[*4]
      |-> aux_powered_o == !aux_loop_power_down_i) else $error("aux power wrong");
  a_lock_drop:
    assert property (main_lock_o && main_powered_o && main_phase_i.valid
      && !lock_detect_quarter_rate_i && main_phase_i.err_cyc > spl_pkg::MAIN_EXIT_CYC
      |=> !main_lock_o) else $error("lock kept past exit window");
  a_both_lock:
    assert property ((test_output_select_i == spl_pkg::SEL_BOTH_LOCK && !main_lock_o)[*3]
      |-> !test_lock_output_pin_o) else $error("combined lock high");
  a_pd_pin_low:
    assert property ((test_output_select_i == spl_pkg::SEL_MAIN_LOCK && !main_powered_o)[*3]
      |-> !test_lock_output_pin_o) else $error("lock pin high while off");
  a_write_aid:
    assert property (s_write_aid ##1 ($stable(cycle_slip_reduction_i) && main_powered_o)
      |-> aid_active_o
      && boost_resistor_o == (cycle_slip_reduction_i == 2'h0) && comp_divide_o == (5'h01
      << (cycle_slip_reduction_i == 2'h3 ? 3'h4 : {1'b0, cycle_slip_reduction_i})))
    else $error("aid not engaged");
  a_aid_timeout:
    assert property ($rose(aid_active_o) |-> ##[1:200] !aid_active_o) else $error("aid stuck");
  a_aid_idle:
    assert property (!aid_active_o |-> comp_divide_o == 5'h01 && !boost_resistor_o)
    else $error("aid output while idle");
endmodule
bind spl_top spl_top_sva spl_top_sva_inst (.clock_i, .nrst_i, .power_enable_i,
  .aux_loop_power_down_i, .divider_write_i, .lock_detect_quarter_rate_i,
  .test_output_select_i, .main_phase_i, .cycle_slip_reduction_i, .boost_enable_i,
  .main_powered_o, .aux_powered_o, .main_lock_o, .test_lock_output_pin_o,
  .comp_divide_o, .boost_resistor_o, .aid_active_o);
`default_nettype wire

// File: verif/spl_phase_model.sv
// Purpose: Phase detector model facing spl_top
// Assumes: One comparison every 16 core cycles
// Notes: Error lines toggle outside samples
`default_nettype none
module spl_phase_model (
  input wire logic clock_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic [7:0] main_err_i, // Main error
  input wire logic [7:0] aux_err_i, // Aux error
  output var spl_pkg::spl_phase_type main_phase_o, // Main sample
  output var spl_pkg::spl_phase_type aux_phase_o // Aux sample
);
  logic [3:0] tick_r;
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      tick_r <= 4'h0;
      main_phase_o <= '0;
      aux_phase_o <= '0;
    end
    else
    begin
      tick_r <= tick_r + 4'h1;
      main_phase_o <= {tick_r == 4'hf, tick_r == 4'hf ? main_err_i : ~main_phase_o.err_cyc};
      aux_phase_o <= {tick_r == 4'hf, tick_r == 4'hf ? aux_err_i : ~aux_phase_o.err_cyc};
    end
endmodule
`default_nettype wire

// File: verif/spl_top_bench.sv
// Purpose: Self-checking bench for spl_top
// Assumes: Model gives one sample every 16 cycles
// Notes: Aid timeout set to three samples
`default_nettype none
module spl_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ME = spl_pkg::MAIN_ENTRY_CYC;
  logic clock_i = 1'b0, nrst_i = 1'b0, pin = 1'b1, mpd = 1'b0, apd = 1'b0, auto = 1'b0;
  logic dw = 1'b0, qr = 1'b0, boost = 1'b0, mpw, apw, mlk, alk, pin_o, brs, act;
  logic [3:0] sel = 4'h2, cps = 4'h4, cpf = 4'h0, cur;
  logic [1:0] slip = 2'h0;
  logic [4:0] div;
  logic [7:0] merr = 8'h0, aerr = 8'h0;
  spl_pkg::spl_phase_type mph, aph;
  int errors = 0, num_checks = 0, seed = 32'hd407;
  always #2 clock_i = ~clock_i;
  spl_phase_model spl_phase_model_inst (.clock_i, .nrst_i, .main_err_i(merr),
    .aux_err_i(aerr), .main_phase_o(mph), .aux_phase_o(aph));
  spl_top #(.TIMEOUT_W(12)) spl_top_inst (.clock_i, .nrst_i, .power_enable_i(pin),
    .main_loop_power_down_i(mpd), .aux_loop_power_down_i(apd),
    .auto_power_up_on_divider_write_i(auto), .divider_write_i(dw),
    .lock_detect_quarter_rate_i(qr), .test_output_select_i(sel), .main_phase_i(mph),
    .aux_phase_i(aph), .cycle_slip_reduction_i(slip), .boost_enable_i(boost),
    .timeout_cycles_i(12'h003), .cp_steady_i(cps), .cp_fast_i(cpf), .main_powered_o(mpw),
    .aux_powered_o(apw), .main_lock_o(mlk), .aux_lock_o(alk), .test_lock_output_pin_o(pin_o),
    .comp_divide_o(div), .cp_current_o(cur), .boost_resistor_o(brs), .aid_active_o(act));
  task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
    num_checks++;
    if (exp !== got)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // Errors drawn from lo up to lo plus span less one
  task automatic feed(input int n, input logic [7:0] lo, input logic [7:0] span);
    repeat (n)
    begin
      // Keep clear of a sample already captured by the model
      while (mph.valid)
        cyc(1);
      merr = lo + 8'($unsigned($random(seed)) % span);
      aerr = 8'($unsigned($random(seed)) % spl_pkg::AUX_ENTRY_CYC);
      @(posedge clock_i iff mph.valid);
      #1;
    end
  endtask
  function automatic logic [4:0] exp_div(input logic [1:0] c);
    return c == spl_pkg::SLIP_SIXTEENTH ? 5'h10 : 5'h01 << c;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    cyc(8);
    nrst_i = 1'b1;
    cyc(4);
    chk("aux power", 5'h1, 5'(apw));
    {apd, mpd} = 2'h3;
    cyc(2);
    chk("main power", 5'h0, 5'(mpw));
    {auto, dw} = 2'h3;
    cyc(1);
    dw = 1'b0;
    cyc(1);
    chk("main power", 5'h1, 5'(mpw));
    chk("aux power", 5'h0, 5'(apw));
    pin = 1'b0;
    cyc(4);
    chk("main power", 5'h0, 5'(mpw));
    {pin, auto, mpd, apd} = 4'h8;
    cyc(4);
    $display("power test done");
    feed(2, ME, 8'h1);
    feed(4, 8'h0, ME);
    feed(1, ME, 8'h1);
    feed(4, 8'h0, ME);
    chk("main lock", 5'h0, 5'(mlk));
    feed(1, 8'h0, ME);
    chk("main lock", 5'h1, 5'(mlk));
    sel = spl_pkg::SEL_BOTH_LOCK;
    feed(1, spl_pkg::MAIN_EXIT_CYC, 8'h1);
    cyc(2);
    chk("aux lock", 5'h1, 5'(alk));
    chk("combined pin", 5'h1, 5'(pin_o));
    feed(1, spl_pkg::MAIN_EXIT_CYC + 8'h1, 8'h1);
    chk("main lock", 5'h0, 5'(mlk));
    cyc(2);
    chk("combined pin", 5'h0, 5'(pin_o));
    qr = 1'b1;
    feed(16, 8'h0, ME);
    chk("main lock", 5'h0, 5'(mlk));
    feed(4, 8'h0, ME);
    chk("main lock", 5'h1, 5'(mlk));
    {qr, mpd, sel} = {2'h1, spl_pkg::SEL_MAIN_LOCK};
    cyc(4);
    chk("lock pin", 5'h0, 5'(pin_o));
    mpd = 1'b0;
    cyc(4);
    $display("lock test done");
    for (int c = 0; c < 4; c++)
    begin
      {slip, boost, dw, cpf} = {2'(c), c == 0, 1'b1, 4'($random(seed))};
      cyc(1);
      dw = 1'b0;
      chk("divide", exp_div(slip), div);
      chk("resistor", 5'(c == 0), 5'(brs));
      chk("current", 5'(cpf), 5'(cur));
      feed(2, 8'h0, ME);
      chk("aid", 5'h1, 5'(act));
      feed(1, 8'h0, ME);
      cyc(2);
      chk("aid", 5'h0, 5'(act));
      chk("current", 5'(cps), 5'(cur));
    end
    $display("aid test done");
    tally_and_finish;
  end
  // About thirteen times the expected run
  initial
  begin
    #40000;
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
